/* design/lrs_pkg.sv */
package lrs_pkg;

	// ==========================================
	// sizes
	localparam int LRS_RAM_DEPTH = 16;
	localparam int LRS_RAM_AW = 4;
	localparam int LRS_SRL_DEPTH = 32;
	localparam int LRS_SRL_AW = 5;
	localparam int LRS_TAP_ZERO = 0;

	// ==========================================
	// modes
	typedef enum logic [1:0] {
		LRS_MODE_RAM1,
		LRS_MODE_RAM2,
		LRS_MODE_SRL1,
		LRS_MODE_SRL2
	} lrs_mode_t;

	typedef struct packed {
		logic write_en;
		logic first_data_in;
		logic second_data_in;
		logic [LRS_SRL_AW-1:0] addr;
	} lrs_req_t;

	typedef struct packed {
		logic first_data_out;
		logic second_data_out;
		logic last_stage_cascade_out;
		logic second_cascade_out;
	} lrs_rsp_t;

endpackage

/* design/lrs_chain.sv */
`timescale 1ns/100ps
module lrs_chain #(
	parameter int DEPTH = lrs_pkg::LRS_SRL_DEPTH,
	parameter int AW = lrs_pkg::LRS_SRL_AW
) (
	input wire logic clk,
	input wire logic shift_en,
	input wire logic wr_en,
	input wire logic serial_data_in,
	input wire logic [AW-1:0] addr,
	output logic tap_out,
	output logic last_out
);

	// ==========================================
	// storage, no reset
	logic [DEPTH-1:0] cells_q;
	logic [DEPTH-1:0] cells_d;
	logic [DEPTH-1:0] shifted;
	logic [DEPTH-1:0] written;

	assign shifted = {cells_q[DEPTH-2:0], serial_data_in};
	always_comb begin
		written = cells_q;
		written[addr] = serial_data_in;
	end
	assign cells_d = shift_en ? shifted : (wr_en ? written : cells_q);

	always_ff @(posedge clk) begin
		cells_q <= cells_d;
	end

	assign tap_out = cells_q[addr];
	assign last_out = cells_q[DEPTH-1];

endmodule

/* design/lrs_top.sv */
`timescale 1ns/100ps
module lrs_top #(
	parameter int SRL_DEPTH = lrs_pkg::LRS_SRL_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire lrs_pkg::lrs_mode_t mode,
	input wire lrs_pkg::lrs_req_t req,
	output lrs_pkg::lrs_rsp_t rsp
);

	// ==========================================
	// mode decode
	wire is_srl;
	wire is_two;
	wire ram_we;
	wire srl_we;
	wire [lrs_pkg::LRS_SRL_AW-1:0] ram_addr;
	wire [lrs_pkg::LRS_SRL_AW-1:0] eff_addr;
	wire tap_a;
	wire tap_b;
	wire last_a;
	wire last_b;

	assign is_srl = (mode == lrs_pkg::LRS_MODE_SRL1) || (mode == lrs_pkg::LRS_MODE_SRL2);
	assign is_two = (mode == lrs_pkg::LRS_MODE_RAM2) || (mode == lrs_pkg::LRS_MODE_SRL2);
	assign ram_we = req.write_en && !is_srl;
	assign srl_we = req.write_en && is_srl;
	assign ram_addr = {1'b0, req.addr[lrs_pkg::LRS_RAM_AW-1:0]};
	assign eff_addr = is_srl ? req.addr : ram_addr;

	// ==========================================
	// two chains
	lrs_chain #(.DEPTH(SRL_DEPTH), .AW(lrs_pkg::LRS_SRL_AW)) u_chain_a (
		.clk(clk),
		.shift_en(srl_we),
		.wr_en(ram_we),
		.serial_data_in(req.first_data_in),
		.addr(eff_addr),
		.tap_out(tap_a),
		.last_out(last_a)
	);

	lrs_chain #(.DEPTH(SRL_DEPTH), .AW(lrs_pkg::LRS_SRL_AW)) u_chain_b (
		.clk(clk),
		.shift_en(srl_we && is_two),
		.wr_en(ram_we && is_two),
		.serial_data_in(req.second_data_in),
		.addr(eff_addr),
		.tap_out(tap_b),
		.last_out(last_b)
	);

	// ==========================================
	// outputs, combinational lookup
	assign rsp.first_data_out = tap_a;
	assign rsp.second_data_out = is_two ? tap_b : 1'b0;
	assign rsp.last_stage_cascade_out = is_srl ? last_a : 1'b0;
	assign rsp.second_cascade_out = (is_srl && is_two) ? last_b : 1'b0;

	// ==========================================
	// checks
	logic [SRL_DEPTH-1:0] hist_q;
	logic [5:0] cnt_q;
	always_ff @(posedge clk) begin
		if (sys_rst || ram_we) begin
			cnt_q <= 6'h00;
		end else if (srl_we && cnt_q != 6'h3f) begin
			cnt_q <= cnt_q + 6'h01;
		end
		if (srl_we) begin
			hist_q <= {hist_q[SRL_DEPTH-2:0], req.first_data_in};
		end
	end

	AST_WRITE_READBACK: assert property (@(posedge clk) disable iff (sys_rst)
		ram_we ##1 (mode == $past(mode) && req.addr == $past(req.addr))
		|-> rsp.first_data_out == $past(req.first_data_in))
		else $error("ram write not read back");
	AST_TWO_BIT: assert property (@(posedge clk) disable iff (sys_rst)
		(ram_we && is_two) ##1 (is_two && !is_srl && req.addr == $past(req.addr))
		|-> rsp.second_data_out == $past(req.second_data_in))
		else $error("second bit not written");
	AST_TAP_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		srl_we ##1 (is_srl && req.addr == 5'h00)
		|-> rsp.first_data_out == $past(req.first_data_in))
		else $error("tap zero not newest bit");
	AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		(!req.write_en && is_srl) ##1 (is_srl && req.addr == $past(req.addr))
		|-> $stable(rsp.first_data_out))
		else $error("contents changed while disabled");
	AST_TAP_K: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_q >= 6'h20 && is_srl) |-> rsp.first_data_out == hist_q[req.addr])
		else $error("tap does not match history");
	AST_CASCADE: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_q >= 6'h20 && is_srl) |-> rsp.last_stage_cascade_out == hist_q[SRL_DEPTH-1])
		else $error("cascade not 32 shifts back");
	AST_SHIFT_ONLY_EN: assert property (@(posedge clk) disable iff (sys_rst)
		(is_srl && !req.write_en) ##1 is_srl |-> $stable(rsp.last_stage_cascade_out))
		else $error("shift without enable");
	AST_RAM_NO_CASCADE: assert property (@(posedge clk) disable iff (sys_rst)
		!is_srl |-> !rsp.last_stage_cascade_out)
		else $error("cascade active in ram mode");

	COV_RAM_WRITE: cover property (@(posedge clk) ram_we ##1 !req.write_en);
	COV_SRL_FULL: cover property (@(posedge clk) cnt_q == 6'h20);
	COV_TWO_CHAINS: cover property (@(posedge clk) srl_we && is_two);

endmodule

/* dv/lrs_user.sv */
`timescale 1ns/100ps
module lrs_user (
	input wire logic clk,
	input wire lrs_pkg::lrs_req_t want,
	input wire logic peek_en,
	input wire logic [4:0] peek,
	output lrs_pkg::lrs_req_t req
);
	lrs_pkg::lrs_req_t held_q = '0;
	// ==========
	// request launched after edge, held over next
	always @(posedge clk) held_q <= #1 want;
	// address moved between edges only when idle
	always_comb begin
		req = held_q;
		if (peek_en && !held_q.write_en) req.addr = peek;
	end
endmodule

/* dv/tb_lrs_top.sv */
`timescale 1ns/100ps
module tb_lrs_top;
	logic clk = 1'b0, sys_rst = 1'b1, peek_en = 1'b0;
	logic [4:0] peek = 5'h00;
	logic [31:0] a, b;
	logic [31:0] rng = 32'h0000_1dd6;
	lrs_pkg::lrs_mode_t mode = lrs_pkg::LRS_MODE_SRL2;
	lrs_pkg::lrs_req_t want = '0;
	lrs_pkg::lrs_req_t req;
	lrs_pkg::lrs_rsp_t rsp;
	int failures = 0, total_checks = 0, cyc = 0;
	lrs_top DUT (.clk(clk), .sys_rst(sys_rst), .mode(mode), .req(req), .rsp(rsp));
	lrs_user USR (.clk(clk), .want(want), .peek_en(peek_en), .peek(peek), .req(req));
	initial forever #5 clk = ~clk;
	// ==========
	// reference storage
	always @(posedge clk) if (req.write_en === 1'b1) begin
		if (mode[1]) begin
			a = {a[30:0], req.first_data_in};
			if (mode[0]) b = {b[30:0], req.second_data_in};
		end else begin
			a[req.addr[3:0]] = req.first_data_in;
			if (mode[0]) b[req.addr[3:0]] = req.second_data_in;
		end
	end
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic lrs_pkg::lrs_rsp_t exp_rsp(logic [4:0] ad);
		logic [4:0] ix;
		ix = mode[1] ? ad : {1'b0, ad[3:0]};
		exp_rsp.first_data_out = a[ix];
		exp_rsp.second_data_out = mode[0] ? b[ix] : 1'b0;
		exp_rsp.last_stage_cascade_out = mode[1] ? a[31] : 1'b0;
		exp_rsp.second_cascade_out = (mode == lrs_pkg::LRS_MODE_SRL2) ? b[31] : 1'b0;
	endfunction
	task automatic cmp_rsp(lrs_pkg::lrs_rsp_t e);
		total_checks++;
		if (rsp !== e) begin
			failures++;
			$display("unexpected rsp expected %h seen %h", e, rsp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ==========
	// one cycle: check, launch next, maybe move address
	task automatic step(logic fill);
		lrs_pkg::lrs_req_t nxt;
		@(posedge clk);
		#3;
		cmp_rsp(exp_rsp(req.addr));
		rng = xs(rng);
		nxt = rng[7:0];
		nxt.write_en = rng[7] | fill;
		want = nxt;
		if (!req.write_en && rng[9]) begin
			peek = rng[14:10];
			peek_en = 1'b1;
			#2;
			cmp_rsp(exp_rsp(peek));
			peek_en = 1'b0;
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 sys_rst = 1'b0;
		repeat (40) step(1'b1);
		$display("test fill done");
		for (int m = 0; m < 4; m++) begin
			mode = lrs_pkg::lrs_mode_t'(m);
			repeat (60) step(1'b0);
			$display("test mode %0d done", m);
		end
		print_verdict();
	end
endmodule
